// file: dspb_param_bank.sv
`include "dspb_regs.svh"
`default_nettype none
// Behaviour
// - Hold signed 32-bit denominator, 1 to 2147483647, reset 16384.
// - Hold numerator, reset 1; new ratio applied only on numerator write.
// - Scaling writes refused while the power stage is enabled.
// - Quick stop code -1 ramps down then enters fault state 9.
// - Quick stop code 6, the default, ramps down and stays in state 7.
// - Quick stop uses decel ramp with velocity profile, else torque ramp.
// - Release mode 0 off, 1 allows reset, 2 also suppresses at enable.
// - Release mode acts only if cyclic synchronous mode is selected at the power-stage enable.
// - A new release mode takes effect at the next power-stage enable.
// - Mode selector decodes 0,-1,1,3,6,8; changes act immediately.
// - Mode selector is 8-bit signed over objects, 16-bit otherwise.
// - Alias mode keeps the station address at offset 12 hex.
// - A changed alias address is applied only after a power cycle.
// - Switch mode shows low digit plus sixteen times high digit at 0FFE.
// - Web traffic served only in pre-operational state or higher.
module dspb_param_bank (
    input  wire logic                    sys_clk,       // 250 MHz clock
    input  wire logic                    rst_b,         // Async reset, low
    input  wire logic                    wrEn,          // Write strobe
    input  wire logic                    rdEn,          // Read strobe
    input  wire logic                    objAccess,     // Indexed-object path
    input  wire logic [`DSPB_ADDR_W-1:0] addr,          // Parameter address
    input  wire logic [31:0]             wrData,        // Write data
    input  wire logic                    powerEnabled,  // Power stage on
    input  wire logic                    quickStopReq,  // Quick stop request
    input  wire logic                    aliasMode,     // 1 alias, 0 switch
    input  wire logic [3:0]              lowDigitSwitch,  // Ones digit
    input  wire logic [3:0]              highDigitSwitch, // Sixteens digit
    input  wire logic [3:0]              esmState,      // Fieldbus state
    input  wire logic                    webReq,        // Web request
    output logic      [31:0]             rdData,        // Read data
    output logic                         rdValid,       // Read answer pulse
    output logic                         wrAck,         // Write taken pulse
    output logic                         wrErr,         // Write refused pulse
    output logic      [31:0]             activeDenom,   // Applied denominator
    output logic      [31:0]             activeNumer,   // Applied numerator
    output dspb_pkg::dspb_opmode_t       opMode,        // Decoded mode
    output dspb_pkg::dspb_qstop_t        qstopAction,   // Quick stop action
    output logic      [3:0]              stopState,     // Target state
    output dspb_pkg::dspb_limrel_t       limRelease,    // Effective release
    output logic      [7:0]              stationAddr,   // Fixed bus address
    output logic                         webGrant       // Web served pulse
);
    // -------------------------------------------------------------
    // Decode helpers
    // -------------------------------------------------------------
    // Unknown codes map to a spare encoding so writes can be refused.
    function automatic dspb_pkg::dspb_opmode_t decodeMode(
        input logic [15:0] v);
        case (v)
            16'h0000: decodeMode = dspb_pkg::DSPB_OP_RESERVED;
            16'hffff: decodeMode = dspb_pkg::DSPB_OP_JOG;
            16'h0001: decodeMode = dspb_pkg::DSPB_OP_PPOS;
            16'h0003: decodeMode = dspb_pkg::DSPB_OP_PVEL;
            16'h0006: decodeMode = dspb_pkg::DSPB_OP_HOMING;
            16'h0008: decodeMode = dspb_pkg::DSPB_OP_CSP;
            default:  decodeMode = dspb_pkg::DSPB_OP_INVALID;
        endcase
    endfunction : decodeMode

    // Any code outside the decode table counts as refused.
    function automatic logic isMode(input logic [15:0] v);
        isMode = (decodeMode(v) != dspb_pkg::DSPB_OP_INVALID);
    endfunction : isMode

    // -------------------------------------------------------------
    // Stored parameters
    // -------------------------------------------------------------
    // Stored values, as last accepted from the master.
    logic [31:0] denom;
    logic [31:0] numer;
    logic [15:0] qstop;
    logic [15:0] limRel;
    logic [15:0] opSel;
    logic [15:0] aliasStore;
    logic [7:0]  aliasLatched;
    logic        aliasTaken;
    logic        powerPrev;

    // -------------------------------------------------------------
    // Write acceptance: a refused write keeps the old value and
    // answers with wrErr instead of wrAck.
    // -------------------------------------------------------------
    wire selLimRel = (addr == `DSPB_OFF_LIMREL);
    wire selDenom  = (addr == `DSPB_OFF_DENOM);
    wire selNumer  = (addr == `DSPB_OFF_NUMER);
    wire selQstop  = (addr == `DSPB_OFF_QSTOP);
    wire selOpMode = (addr == `DSPB_OFF_OPMODE);
    wire selAlias  = (addr == `DSPB_OFF_ALIAS);
    wire selSwAddr = (addr == `DSPB_OFF_SWADDR);

    // Over the object path the mode is 8 bits; sign-extend to 16.
    wire [15:0] modeIn = objAccess ? {{8{wrData[7]}}, wrData[7:0]}
                                   : wrData[15:0];


    wire scaleOk = !powerEnabled && !wrData[31]
                   && (wrData != 32'h0000_0000);
    // Only -1..6 is stored; a master asking for -2 gets wrErr and the
    // previous reaction stays in force.
    wire qstopOk = (wrData[15:0] == `DSPB_QS_FAULT)
                   || (!wrData[15] && wrData[15:0] <= `DSPB_QS_STAY);
    wire limOk   = !powerEnabled
                   && (wrData[15:0] <= `DSPB_LIMREL_MAX);

    wire okDenom  = selDenom  && scaleOk;
    wire okNumer  = selNumer  && scaleOk;
    wire okQstop  = selQstop  && qstopOk;
    wire okLimRel = selLimRel && limOk;
    wire okOpMode = selOpMode && isMode(modeIn);
    wire okAlias  = selAlias;
    wire wrOk     = okDenom || okNumer || okQstop || okLimRel
                    || okOpMode || okAlias;

    // -------------------------------------------------------------
    // Parameter storage
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            denom  <= `DSPB_RST_DENOM;
            numer  <= `DSPB_RST_NUMER;
            qstop  <= 16'(`DSPB_RST_QSTOP);
            limRel <= 16'(`DSPB_RST_LIMREL);
            opSel  <= 16'(`DSPB_RST_OPMODE);
        end else if (wrEn) begin
            if (okDenom) begin
                denom <= wrData;
            end
            if (okNumer) begin
                numer <= wrData;
            end
            if (okQstop) begin
                qstop <= wrData[15:0];
            end
            if (okLimRel) begin
                limRel <= wrData[15:0];
            end
            if (okOpMode) begin
                opSel <= modeIn;
            end
        end
    end

    // -------------------------------------------------------------
    // Alias store
    // -------------------------------------------------------------
    // The alias store keeps its value through rst_b, as a stored
    // address outlives a power cycle; only the latched copy restarts.
    always_ff @(posedge sys_clk) begin
        if (wrEn && okAlias) begin
            aliasStore <= wrData[15:0];
        end
    end

    // -------------------------------------------------------------
    // Applied scaling: the denominator alone never changes the ratio.
    // -------------------------------------------------------------
    // The denominator is taken from the store at the numerator write,
    // so a master must write the denominator first.
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            activeDenom <= `DSPB_RST_DENOM;
            activeNumer <= `DSPB_RST_NUMER;
        end else if (wrEn && okNumer) begin
            activeDenom <= denom;
            activeNumer <= wrData;
        end
    end

    // -------------------------------------------------------------
    // Operating mode and quick stop reaction
    // -------------------------------------------------------------
    wire dspb_pkg::dspb_opmode_t next_opMode = decodeMode(opSel);
    wire velProfile = (next_opMode == dspb_pkg::DSPB_OP_JOG)
                      || (next_opMode == dspb_pkg::DSPB_OP_PPOS)
                      || (next_opMode == dspb_pkg::DSPB_OP_PVEL)
                      || (next_opMode == dspb_pkg::DSPB_OP_HOMING);

    // Reaction codes other than -1 and 6 give no target state here.
    wire isFault = (qstop == `DSPB_QS_FAULT);
    wire isStay  = (qstop == `DSPB_QS_STAY);
    wire dspb_pkg::dspb_qstop_t next_qstop = '{
        stopToFault:   quickStopReq && isFault,
        stopStay:      quickStopReq && isStay,
        useDecelRamp:  quickStopReq && velProfile,
        useTorqueRamp: quickStopReq && !velProfile
    };
    wire [3:0] next_stopState = !quickStopReq ? 4'h0 :
                                isFault ? 4'h9 :
                                isStay  ? 4'h7 : 4'h0;

    // Every register in the block below except limRelease reloads on each edge from its next value; limRelease loads only at enableEdge.

    // Release mode is latched at the enable edge, so a write made while
    // the stage is off never alters a motion already in progress.
    wire enableEdge = powerEnabled && !powerPrev;
    wire cyclic     = (next_opMode == dspb_pkg::DSPB_OP_CSP);
    wire dspb_pkg::dspb_limrel_t next_limRelease = '{
        resetAllowed:     cyclic && (limRel != 16'h0000),
        suppressAtEnable: cyclic && (limRel == `DSPB_LIMREL_MAX)
    };

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            opMode      <= dspb_pkg::DSPB_OP_RESERVED;
            qstopAction <= '0;
            stopState   <= 4'h0;
            limRelease  <= '0;
            powerPrev   <= 1'b0;
        end else begin
            opMode      <= next_opMode;
            qstopAction <= next_qstop;
            stopState   <= next_stopState;
            powerPrev   <= powerEnabled;
            if (enableEdge) begin
                limRelease <= next_limRelease;
            end
        end
    end

    // -------------------------------------------------------------
    // Station address: alias captured once after reset (power cycle).
    // -------------------------------------------------------------
    // Only the low byte of the alias store forms the address; the
    // upper byte is kept for reads but never reaches stationAddr.
    wire [7:0] switchAddr = {highDigitSwitch, lowDigitSwitch};

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            aliasLatched <= 8'h00;
            aliasTaken   <= 1'b0;
            stationAddr  <= 8'h00;
        end else begin
            if (!aliasTaken) begin
                aliasLatched <= aliasStore[7:0];
                aliasTaken   <= 1'b1;
            end
            stationAddr <= aliasMode ? aliasLatched : switchAddr;
        end
    end

    // -------------------------------------------------------------
    // Read path and write answers
    // -------------------------------------------------------------
    wire [31:0] next_rdData =
        selDenom  ? denom :
        selNumer  ? numer :
        selQstop  ? {{16{qstop[15]}}, qstop} :
        selLimRel ? {16'h0000, limRel} :
        selOpMode ? (objAccess ? {{24{opSel[7]}}, opSel[7:0]}
                               : {{16{opSel[15]}}, opSel}) :
        selAlias  ? {16'h0000, aliasStore} :
        selSwAddr ? {24'h000000, switchAddr} :
                    32'h0000_0000;


    // Web traffic is gated on the fieldbus state, one cycle late.
    wire next_webGrant = webReq && (esmState >= `DSPB_ESM_PREOP);

    // -------------------------------------------------------------
    // Answer pulses
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdValid  <= 1'b0;
            wrAck    <= 1'b0;
            wrErr    <= 1'b0;
            webGrant <= 1'b0;
        end else begin
            rdValid  <= rdEn && !wrEn;
            wrAck    <= wrEn && wrOk;
            wrErr    <= wrEn && !wrOk;
            webGrant <= next_webGrant;
        end
    end

    // -------------------------------------------------------------
    // Read data: held until the next read, so a slow master can still
    // pick it up after the rdValid pulse.
    // -------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData <= 32'h0000_0000;
        end else if (rdEn && !wrEn) begin
            rdData <= next_rdData;
        end
    end
endmodule : dspb_param_bank
`default_nettype wire

// file: dspb_regs.svh
`ifndef DSPB_REGS_SVH
`define DSPB_REGS_SVH
`define DSPB_ADDR_W          16
`define DSPB_OFF_LIMREL      16'h060c
`define DSPB_OFF_DENOM       16'h060e
`define DSPB_OFF_NUMER       16'h0610
`define DSPB_OFF_QSTOP       16'h0630
`define DSPB_OFF_OPMODE      16'h1b06
`define DSPB_OFF_ALIAS       16'h0012
`define DSPB_OFF_SWADDR      16'h0ffe
`define DSPB_RST_LIMREL      32'h0000_0000
`define DSPB_RST_DENOM       32'h0000_4000
`define DSPB_RST_NUMER       32'h0000_0001
`define DSPB_RST_QSTOP       32'h0000_0006
`define DSPB_RST_OPMODE      32'h0000_0000
`define DSPB_RST_ALIAS       16'h0000
`define DSPB_DENOM_MAX       32'h7fff_ffff
`define DSPB_QS_FAULT        16'hffff
`define DSPB_QS_STAY         16'h0006
`define DSPB_LIMREL_MAX      16'h0002
`define DSPB_ESM_PREOP       4'h2
`endif

// file: dspb_pkg.sv
`default_nettype none
package dspb_pkg;
    typedef enum logic [2:0] {
        DSPB_OP_RESERVED = 3'b000,
        DSPB_OP_JOG      = 3'b001,
        DSPB_OP_PPOS     = 3'b010,
        DSPB_OP_PVEL     = 3'b011,
        DSPB_OP_HOMING   = 3'b100,
        DSPB_OP_CSP      = 3'b101,
        DSPB_OP_INVALID  = 3'b111
    } dspb_opmode_t;

    typedef struct packed {
        logic        stopToFault;
        logic        stopStay;
        logic        useDecelRamp;
        logic        useTorqueRamp;
    } dspb_qstop_t;

    typedef struct packed {
        logic        resetAllowed;
        logic        suppressAtEnable;
    } dspb_limrel_t;
endpackage : dspb_pkg
`default_nettype wire

// file: dspb_param_bank_props.sv
`include "dspb_regs.svh"
`default_nettype none
module dspb_param_bank_props (
    input wire logic                    sys_clk,      // Clock
    input wire logic                    rst_b,        // Reset, low
    input wire logic                    wrEn,         // Write strobe
    input wire logic [`DSPB_ADDR_W-1:0] addr,         // Address
    input wire logic [31:0]             wrData,       // Write data
    input wire logic                    powerEnabled, // Power on
    input wire logic                    wrAck,        // Write taken
    input wire logic                    wrErr,        // Write refused
    input wire logic [31:0]             activeDenom,  // Applied denom
    input wire logic [31:0]             activeNumer,  // Applied numer
    input wire dspb_pkg::dspb_qstop_t   qstopAction,  // Stop action
    input wire logic [3:0]              stopState,    // Target state
    input wire dspb_pkg::dspb_limrel_t  limRelease    // Release mode
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // Scaling writes
    // ------------------------------------------------------------
    sequence s_scaleWr;
        wrEn && (addr == `DSPB_OFF_DENOM || addr == `DSPB_OFF_NUMER);
    endsequence
    sequence s_numOk;
        wrEn && addr == `DSPB_OFF_NUMER && !powerEnabled
            && !wrData[31] && wrData != 32'h0;
    endsequence
    property p_wrAnswer;
        wrEn |=> wrAck != wrErr;
    endproperty
    property p_scaleLock;
        s_scaleWr and powerEnabled |=> wrErr && $stable(activeDenom);
    endproperty
    property p_numApply;
        s_numOk |=> wrAck && activeNumer == $past(wrData);
    endproperty
    property p_denomHold;
        wrEn && addr == `DSPB_OFF_DENOM |=> $stable(activeDenom);
    endproperty
    property p_fault;
        stopState == 4'h9 |-> qstopAction.stopToFault && !qstopAction.stopStay;
    endproperty
    property p_stay;
        stopState == 4'h7 |-> qstopAction.stopStay && !qstopAction.stopToFault;
    endproperty
    property p_rampOne;
        qstopAction != 4'h0 |->
            qstopAction.useDecelRamp != qstopAction.useTorqueRamp;
    endproperty
    // A new release mode may only land just after a power-stage enable.
    property p_limHold;
        $changed(limRelease) |-> $past(powerEnabled)
            && (!$past(powerEnabled, 2) || !$past(powerEnabled, 3));
    endproperty
    a_wrAnswer: assert property (p_wrAnswer) else $error("no answer");
    a_scaleLock: assert property (p_scaleLock) else $error("lock");
    a_numApply: assert property (p_numApply) else $error("numer");
    a_denomHold: assert property (p_denomHold) else $error("denom");
    a_fault: assert property (p_fault) else $error("fault stop");
    a_stay: assert property (p_stay) else $error("stay stop");
    a_rampOne: assert property (p_rampOne) else $error("ramp");
    a_limHold: assert property (p_limHold) else $error("release");
endmodule : dspb_param_bank_props
bind dspb_param_bank dspb_param_bank_props u_props (.*);
`default_nettype wire

// file: dspb_master.sv
`include "dspb_regs.svh"
`default_nettype none
module dspb_master (
    input  wire logic                    sys_clk,   // Clock
    input  wire logic                    wrErr,     // Write refused
    input  wire logic                    rdValid,   // Read answer
    input  wire logic [31:0]             rdData,    // Read data
    output var  logic                    wrEn,      // Write strobe
    output var  logic                    rdEn,      // Read strobe
    output var  logic                    objAccess, // Object path
    output var  logic [`DSPB_ADDR_W-1:0] addr,      // Address
    output var  logic [31:0]             wrData     // Write data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wrEn = 1'b0;
        rdEn = 1'b0;
        objAccess = 1'b0;
        addr = 16'h0;
        wrData = 32'h0;
    end
    // ------------------------------------------------------------
    // One access, strobe held for exactly one edge
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [31:0] d, input logic o,
                        output logic e, output logic [31:0] v);
        @(posedge sys_clk);
        wrEn      <= w;
        rdEn      <= !w;
        objAccess <= o;
        addr      <= a;
        wrData    <= d;
        @(posedge sys_clk);
        wrEn      <= 1'b0;
        rdEn      <= 1'b0;
        wrData    <= ~d;
        #1;
        e = wrErr;
        v = rdValid ? rdData : ~d;
    endtask : xfer
    task automatic startup();
        logic        e;
        logic [31:0] v;
        xfer(1'b1, `DSPB_OFF_DENOM, 32'h0000_8000, 1'b0, e, v);
        xfer(1'b1, `DSPB_OFF_NUMER, 32'h0000_0001, 1'b0, e, v);
        xfer(1'b1, `DSPB_OFF_QSTOP, 32'hffff_fffe, 1'b0, e, v);
        xfer(1'b1, `DSPB_OFF_LIMREL, 32'h0000_0002, 1'b0, e, v);
        xfer(1'b1, `DSPB_OFF_OPMODE, 32'h0000_0008, 1'b1, e, v);
    endtask : startup
endmodule : dspb_master
`default_nettype wire

// file: dspb_param_bank_tb_top.sv
`include "dspb_regs.svh"
`default_nettype none
module dspb_param_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic w; logic [15:0] a; logic [31:0] d; logic o; logic p;
        logic e; logic [31:0] x;
    } dspb_row_t;
    logic sys_clk, rst_b, wrEn, rdEn, objAccess, powerEnabled, quickStopReq;
    logic aliasMode, webReq, rdValid, wrAck, wrErr, webGrant, e;
    logic [15:0] addr;
    logic [31:0] wrData, rdData, activeDenom, activeNumer, v;
    logic [3:0]  lowDigitSwitch, highDigitSwitch, esmState, stopState;
    logic [7:0]  stationAddr;
    dspb_pkg::dspb_opmode_t opMode;
    dspb_pkg::dspb_qstop_t  qstopAction;
    dspb_pkg::dspb_limrel_t limRelease;
    int failures = 0;
    int compares = 0;
    localparam dspb_row_t ROWS [18] = '{
        '{0, `DSPB_OFF_LIMREL, 0, 0, 0, 0, 0},
        '{0, `DSPB_OFF_DENOM, 0, 0, 0, 0, 32'h4000},
        '{0, `DSPB_OFF_NUMER, 0, 0, 0, 0, 1},
        '{0, `DSPB_OFF_QSTOP, 0, 0, 0, 0, 6},
        '{0, `DSPB_OFF_OPMODE, 0, 0, 0, 0, 0},
        '{1, `DSPB_OFF_DENOM, 32'h7fffffff, 0, 0, 0, 32'h7fffffff},
        '{1, `DSPB_OFF_DENOM, 0, 0, 0, 1, 32'h7fffffff},
        '{1, `DSPB_OFF_DENOM, 32'h4000, 0, 1, 1, 32'h7fffffff},
        '{1, `DSPB_OFF_NUMER, 32'h80000000, 0, 0, 1, 1},
        '{1, `DSPB_OFF_QSTOP, 32'hffff, 0, 0, 0, 32'hffffffff},
        '{1, `DSPB_OFF_QSTOP, 7, 0, 0, 1, 32'hffffffff},
        '{1, `DSPB_OFF_LIMREL, 3, 0, 0, 1, 0},
        '{1, `DSPB_OFF_LIMREL, 1, 0, 1, 1, 0},
        '{1, `DSPB_OFF_OPMODE, 2, 0, 0, 1, 0},
        '{1, `DSPB_OFF_OPMODE, 32'hff, 1, 0, 0, 32'hffffffff},
        '{1, `DSPB_OFF_SWADDR, 5, 0, 0, 1, 32'h3c},
        '{1, 16'h5555, 1, 0, 0, 1, 0},
        '{1, `DSPB_OFF_ALIAS, 32'ha5, 0, 0, 0, 32'ha5}
    };
    localparam logic [31:0] CODES [6] = '{32'hffffffff, 1, 3, 6, 8, 0};
    localparam logic [2:0] MODES [6] = '{1, 2, 3, 4, 5, 0};
    dspb_param_bank u_dut (.*);
    dspb_master u_master (.*);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic check(input string n, input logic [31:0] s, x);
        compares++;
        if (s !== x) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask : check
    task automatic test_done();
        if (failures == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_b, powerEnabled, quickStopReq, aliasMode, webReq} = 5'h0;
        {lowDigitSwitch, highDigitSwitch, esmState} = 12'h3c1;
        lowDigitSwitch = 4'hc;
        highDigitSwitch = 4'h3;
        // Seed the alias store, which rst_b leaves alone.
        u_master.xfer(1'b1, `DSPB_OFF_ALIAS, 0, 1'b0, e, v);
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        tick(2);
        check("stationAddr", stationAddr, 32'h3c);
        check("activeDenom", activeDenom, 32'h4000);
        for (int i = 0; i < 18; i++) begin
            @(posedge sys_clk) powerEnabled <= ROWS[i].p;
            if (ROWS[i].w) begin
                u_master.xfer(1'b1, ROWS[i].a, ROWS[i].d, ROWS[i].o, e, v);
                check("wrErr", e, ROWS[i].e);
            end
            u_master.xfer(1'b0, ROWS[i].a, 0, 1'b0, e, v);
            check("rdData", v, ROWS[i].x);
        end
        check("activeDenom", activeDenom, 32'h4000);
        for (int k = 0; k < 6; k++) begin
            u_master.xfer(1'b1, `DSPB_OFF_OPMODE, CODES[k], 1'b0, e, v);
            tick(1);
            check("opMode", opMode, MODES[k]);
        end
        aliasMode <= 1'b1;
        tick(2);
        check("stationAddr", stationAddr, 0);
        u_master.startup();
        check("activeDenom", activeDenom, 32'h8000);
        u_master.xfer(1'b0, `DSPB_OFF_QSTOP, 0, 1'b0, e, v);
        check("quickStop", v, 32'hffffffff);
        @(posedge sys_clk) powerEnabled <= 1'b1;
        quickStopReq <= 1'b1;
        tick(3);
        check("limRelease", limRelease, 2'b11);
        check("stopState", stopState, 9);
        check("qstopAction", qstopAction, 4'b1001);
        u_master.xfer(1'b1, `DSPB_OFF_QSTOP, 6, 1'b0, e, v);
        tick(2);
        check("stopState", stopState, 7);
        @(posedge sys_clk) powerEnabled <= 1'b0;
        u_master.xfer(1'b1, `DSPB_OFF_OPMODE, 3, 1'b0, e, v);
        @(posedge sys_clk) powerEnabled <= 1'b1;
        tick(3);
        check("limRelease", limRelease, 0);
        check("qstopAction", qstopAction, 4'b0110);
        webReq <= 1'b1;
        tick(3);
        check("webGrant", webGrant, 0);
        esmState <= `DSPB_ESM_PREOP;
        tick(3);
        check("webGrant", webGrant, 1);
        rst_b <= 1'b0;
        tick(1);
        @(posedge sys_clk) rst_b <= 1'b1;
        tick(2);
        check("stationAddr", stationAddr, 32'ha5);
        check("activeDenom", activeDenom, 32'h4000);
        check("activeNumer", activeNumer, 1);
        test_done();
    end
    // Roughly 150 cycles are needed; this leaves ample slack.
    initial begin
        #20000;
        failures++;
        test_done();
    end
endmodule : dspb_param_bank_tb_top
`default_nettype wire
